// [cld_pkg.sv]
/*
 * Constants and carrier types for the receive lock controller
 * and deserializer.
 * Assumes one 100 MHz reference clock; no register bus.
 */
// Overview of operation
// - Start in reference tracking after every reset.
// - Phase detector only on while tracking data.
// - Auto mode enters data tracking when ready.
// - Entry needs recovered clock within ppm threshold.
// - PIPE mode: signal detect gates entry, forces exit.
// - Auto mode exits on any exit condition.
// - Auto lock flag follows state switches.
// - Manual mode: two user levels set state.
// - Manual lock flag high exactly in data tracking.
// - No manual inputs enabled means automatic mode.
// - Signal present when level exceeds threshold.
// - Detection unsupported: signal present held high.
// - Fast clock feeds deserializer, word strobe PCS.
// - Words are 8 or 10 bits wide.
// - First serial bit lands in word LSB.
// - Two bits per half-rate clock, both edges.
package cld_pkg;

    // Bits taken per clock: one per recovered-clock edge
    localparam int          BITS_PER_CLK = 2;
    localparam int          WORD_W8      = 8;
    localparam int          WORD_W10     = 10;

    // Frequency check window in reference cycles
    localparam int          PPM_WIN_CYC  = 1024;
    localparam int          PPM_CNT_W    = 12;
    localparam logic [11:0] PPM_WIN_CNT  = 12'h400;
    localparam logic [11:0] PPM_CNT_RST  = 12'h000;

    // Signal detect hysteresis, steady cycles counted before the switching one
    localparam logic [2:0]  SD_FILT_CNT  = 3'h4;
    localparam logic [2:0]  SD_CNT_RST   = 3'h0;

    // Tracking states, Gray coded
    typedef enum logic [1:0] {
        CLD_REF  = 2'b00,   // Reference tracking
        CLD_DATA = 2'b01    // Data tracking
    } cld_state_t;

    // Static configuration
    typedef struct packed {
        logic       manual_en;  // Manual control inputs enabled
        logic       pipe_mode;  // PIPE protocol mode
        logic       enc_en;     // 8B/10B coding enabled
        logic       width10;    // 10-bit words, else 8
        logic [7:0] ppm_thresh; // Allowed tick difference
    } cld_cfg_t;

    // Manual lock controls from user logic
    typedef struct packed {
        logic to_ref;   // Force reference tracking
        logic to_data;  // Request data tracking
    } cld_manual_t;

    // Parallel word to the coding sublayer
    typedef struct packed {
        logic [9:0] data;   // Word, LSB first received
        logic       valid;  // Word strobe, one cycle
    } cld_word_t;

endpackage

// [cld_deser.sv]
/*
 * Serial to parallel converter taking two bits per clock.
 * Assumes the caller holds run low while data is ignored.
 */
`timescale 1ns/1ps
`default_nettype none
module cld_deser #(
    parameter int MAXW = cld_pkg::WORD_W10  // Widest word
) (
    input  wire logic              clk,     // Half-rate clock
    input  wire logic              rst_n,   // Async reset
    input  wire logic              run,     // Capture enable
    input  wire logic              width10, // 10-bit words
    input  wire logic [1:0]        bits,    // bit0 arrives first
    output var cld_pkg::cld_word_t word_o   // Word and strobe
);
    // Refuse widths the fill logic cannot serve
    if (MAXW != cld_pkg::WORD_W10) begin : g_bad
        $error("cld_deser supports MAXW of 10 only");
    end

    logic [MAXW-1:0] sh_r;       // Partial word
    logic [MAXW-1:0] sh_nxt;     // Next partial word
    logic [3:0]      pos_r;      // Next fill position
    logic [3:0]      pos_nxt;    // Fill position next
    logic [3:0]      wlen;       // Current word length
    logic            last;       // This pair ends the word
    cld_pkg::cld_word_t word_r;  // Registered output

    assign wlen = width10 ? 4'(cld_pkg::WORD_W10)
                          : 4'(cld_pkg::WORD_W8);
    assign last = (pos_r + 4'(cld_pkg::BITS_PER_CLK)) == wlen;
    assign pos_nxt = last ? 4'h0
                   : pos_r + 4'(cld_pkg::BITS_PER_CLK);

    // Place each bit at its slot, filling toward MSB
    for (genvar i = 0; i < MAXW; i++) begin : g_fill
        assign sh_nxt[i] = (4'(i) == pos_r)        ? bits[0]
                         : (4'(i) == pos_r + 4'h1) ? bits[1]
                         : sh_r[i];
    end

    // Shift in, strobe the finished word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_r   <= '0;
            pos_r  <= 4'h0;
            word_r <= '0;
        end else if (!run) begin
            pos_r        <= 4'h0;
            word_r.valid <= 1'b0;
        end else begin
            sh_r         <= last ? '0 : sh_nxt;
            pos_r        <= pos_nxt;
            word_r.valid <= last;
            if (last) begin
                word_r.data <= width10 ? sh_nxt
                             : {2'b00, sh_nxt[7:0]};
            end
        end
    end

    assign word_o = word_r;
endmodule
`default_nettype wire

// [cld_top.sv]
/*
 * Receive lock controller with frequency check, signal
 * detect filter and deserializer.
 * Assumes clk is the reference clock, and rec_tick marks
 * one recovered-clock cycle, synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module cld_top #(
    parameter int PPM_WIN = cld_pkg::PPM_WIN_CYC // Window
) (
    input  wire logic               clk,       // 100 MHz
    input  wire logic               rst_n,     // Async reset
    input  wire cld_pkg::cld_cfg_t  cfg,       // Config
    input  wire cld_pkg::cld_manual_t man,     // Manual ctl
    input  wire logic               rec_tick,  // Recovered clk
    input  wire logic               level_hi,  // Above thresh
    input  wire logic [1:0]         rx_bits,   // Serial pair
    output logic                    freq_locked, // Lock flag
    output logic                    pd_en,     // Phase det on
    output logic                    sig_present, // Signal seen
    output var cld_pkg::cld_state_t state_o,   // Track state
    output var cld_pkg::cld_word_t  rx_word    // Parallel word
);
    // Window must fit the counters
    if (PPM_WIN < 16 || PPM_WIN > 2047) begin : g_bad
        $error("cld_top PPM_WIN out of range");
    end

    localparam logic [11:0] WIN_END = 12'(PPM_WIN - 1);
    localparam logic [11:0] WIN_EXP = 12'(PPM_WIN);

    // ---------------------------------------------------
    // Frequency check
    // ---------------------------------------------------

    logic [11:0] win_r;      // Reference cycle count
    logic [11:0] tick_r;     // Recovered tick count
    logic [11:0] tick_fin;   // Ticks incl. this cycle
    logic [11:0] diff;       // Absolute difference
    logic        win_done;   // Window ends now
    logic        ppm_ok_r;   // Within threshold

    assign win_done = (win_r == WIN_END);

    // Include the tick of the closing cycle
    assign tick_fin = tick_r + {11'h000, rec_tick};

    // Magnitude of the frequency error
    assign diff = (tick_fin >= WIN_EXP) ? tick_fin - WIN_EXP
                                        : WIN_EXP - tick_fin;

    // Count one window, then judge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            win_r    <= cld_pkg::PPM_CNT_RST;
            tick_r   <= cld_pkg::PPM_CNT_RST;
            ppm_ok_r <= 1'b0;
        end else if (win_done) begin
            win_r    <= cld_pkg::PPM_CNT_RST;
            tick_r   <= cld_pkg::PPM_CNT_RST;
            // Judged against the configured limit
            ppm_ok_r <= diff <= {4'h0, cfg.ppm_thresh};
        end else begin
            win_r  <= win_r + 12'h001;
            tick_r <= tick_fin;
        end
    end

    // ---------------------------------------------------
    // Signal detect with hysteresis
    // ---------------------------------------------------

    logic [2:0] sd_cnt_r;    // Steady-level counter
    logic       sd_r;        // Filtered detect
    logic       sd_flip;     // Level differs from detect
    logic       sd_settled;  // Level held long enough

    assign sd_flip    = (level_hi != sd_r);
    assign sd_settled = (sd_cnt_r == cld_pkg::SD_FILT_CNT);

    // Change only after a steady run, ignores ringing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sd_cnt_r <= cld_pkg::SD_CNT_RST;
            sd_r     <= 1'b0;
        end else if (!sd_flip) begin
            sd_cnt_r <= cld_pkg::SD_CNT_RST;
        end else if (sd_settled) begin
            sd_r     <= level_hi;
            sd_cnt_r <= cld_pkg::SD_CNT_RST;
        end else begin
            sd_cnt_r <= sd_cnt_r + 3'h1;
        end
    end

    logic sig_present_nxt;   // Detect or bypass
    logic sig_present_r;     // Registered output

    // Without 8B/10B the detector is bypassed high
    assign sig_present_nxt = cfg.enc_en ? sd_r
                                        : 1'b1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sig_present_r <= 1'b0;
        end else begin
            sig_present_r <= sig_present_nxt;
        end
    end

    // ---------------------------------------------------
    // Tracking state controller
    // ---------------------------------------------------

    logic                auto_mode;  // Automatic lock
    logic                sd_gate;    // Detect in PIPE only
    logic                enter_ok;   // Entry conditions
    logic                exit_req;   // Any exit condition
    logic                man_data;   // Manual selection
    cld_pkg::cld_state_t state_r;    // Current state
    cld_pkg::cld_state_t auto_nxt;   // Automatic choice
    cld_pkg::cld_state_t state_nxt;  // Next state

    // Automatic unless manual ports are enabled
    assign auto_mode = !cfg.manual_en;

    // Detector matters only in PIPE mode
    assign sd_gate  = !cfg.pipe_mode || sig_present_r;

    // All entry conditions together
    assign enter_ok = ppm_ok_r && sd_gate;

    // Any exit condition alone
    assign exit_req = !ppm_ok_r || !sd_gate;

    // Reference control takes priority
    assign man_data = !man.to_ref && man.to_data;

    // Decodes a state value as data tracking
    function automatic logic is_data(input cld_pkg::cld_state_t s);
        return s == cld_pkg::CLD_DATA;
    endfunction

    // Automatic transition choice
    always_comb begin
        case (state_r)
            cld_pkg::CLD_REF: begin
                auto_nxt = enter_ok ? cld_pkg::CLD_DATA
                                    : cld_pkg::CLD_REF;
            end
            cld_pkg::CLD_DATA: begin
                auto_nxt = exit_req ? cld_pkg::CLD_REF
                                    : cld_pkg::CLD_DATA;
            end
            default: begin
                auto_nxt = cld_pkg::CLD_REF;
            end
        endcase
    end

    // Manual mode ignores the detectors entirely
    assign state_nxt = auto_mode ? auto_nxt
                     : man_data  ? cld_pkg::CLD_DATA
                                 : cld_pkg::CLD_REF;

    logic freq_locked_r;  // Lock indication
    logic pd_en_r;        // Phase detector enable
    logic nxt_data;       // Next state is data tracking

    // One decode shared by both indications
    assign nxt_data = is_data(state_nxt);

    // State and its indications move together
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r       <= cld_pkg::CLD_REF;
            freq_locked_r <= 1'b0;
            pd_en_r       <= 1'b0;
        end else begin
            state_r       <= state_nxt;
            // Rises on entry, falls on exit
            freq_locked_r <= nxt_data;
            pd_en_r       <= nxt_data;
        end
    end

    // ---------------------------------------------------
    // Deserializer
    // ---------------------------------------------------

    logic run_deser;  // Data used only when tracking it

    assign run_deser = is_data(state_r);

    // Word strobe stands in for the slow recovered clock
    cld_deser #(
        .MAXW    (cld_pkg::WORD_W10)
    ) u_deser (
        .clk     (clk),
        .rst_n   (rst_n),
        .run     (run_deser),
        .width10 (cfg.width10),
        .bits    (rx_bits),
        .word_o  (rx_word)
    );

    // Outputs straight from flip-flops
    assign freq_locked = freq_locked_r;
    assign pd_en       = pd_en_r;
    assign sig_present = sig_present_r;
    assign state_o     = state_r;

    // ---------------------------------------------------
    // Checks
    // ---------------------------------------------------

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Switch into data tracking
    sequence s_enter;
        state_r == cld_pkg::CLD_REF
        ##1 state_r == cld_pkg::CLD_DATA;
    endsequence

    // Switch back to reference tracking
    sequence s_leave;
        state_r == cld_pkg::CLD_DATA
        ##1 state_r == cld_pkg::CLD_REF;
    endsequence

    // First cycle after reset sits in reference tracking
    AST_RESET_REF: assert property (
        disable iff (1'b0)
        !rst_n |=> state_r == cld_pkg::CLD_REF)
        else $error("not in reference tracking after reset");

    // Phase detector matches the state
    AST_PD_STATE: assert property (
        pd_en_r == (state_r == cld_pkg::CLD_DATA)
        && run_deser == pd_en_r)
        else $error("phase detector does not match state");

    // Automatic entry when all conditions hold
    AST_AUTO_ENTER: assert property (
        auto_mode && state_r == cld_pkg::CLD_REF
        && ppm_ok_r
        && (!cfg.pipe_mode || sig_present_r)
        |=> state_r == cld_pkg::CLD_DATA)
        else $error("automatic entry missed");

    // No automatic entry outside the ppm window
    AST_NO_ENTER_PPM: assert property (
        auto_mode && state_r == cld_pkg::CLD_REF
        && !ppm_ok_r
        |=> state_r == cld_pkg::CLD_REF)
        else $error("entered data tracking off frequency");

    // PIPE loss of signal forces the return
    AST_PIPE_LOSS: assert property (
        auto_mode && cfg.pipe_mode && !sig_present_r
        |=> state_r == cld_pkg::CLD_REF)
        else $error("PIPE signal loss did not force exit");

    // Off frequency forces the return
    AST_AUTO_EXIT: assert property (
        auto_mode && !ppm_ok_r
        |=> state_r == cld_pkg::CLD_REF)
        else $error("off frequency did not force exit");

    // Lock rises and falls with the switches
    AST_LOCK_EDGES: assert property (
        s_enter |-> freq_locked_r
        and $past(freq_locked_r) == 1'b0)
        else $error("lock not raised on entry");

    AST_LOCK_FALL: assert property (
        s_leave |-> !freq_locked_r)
        else $error("lock not dropped on exit");

    // Manual reference control wins
    AST_MAN_REF: assert property (
        !auto_mode && man.to_ref
        |=> state_r == cld_pkg::CLD_REF && !freq_locked_r)
        else $error("manual reference control ignored");

    // Manual data control selects data tracking
    AST_MAN_DATA: assert property (
        !auto_mode && !man.to_ref && man.to_data
        |=> state_r == cld_pkg::CLD_DATA && freq_locked_r)
        else $error("manual data control ignored");

    // Manual lock flag equals data tracking
    AST_MAN_LOCK: assert property (
        !auto_mode && $stable(cfg.manual_en)
        |-> freq_locked_r == (state_r == cld_pkg::CLD_DATA))
        else $error("manual lock flag disagrees with state");

    // Bypassed detector reads high
    AST_SD_BYPASS: assert property (
        !cfg.enc_en |=> sig_present_r)
        else $error("bypassed detect not high");

    // Word strobes are at least four cycles apart
    AST_WORD_GAP: assert property (
        rx_word.valid |=> !rx_word.valid [*3])
        else $error("word strobes too close");

    // Detect only moves after a settled run
    AST_SD_HOLD: assert property (
        !sd_settled |=> $stable(sd_r))
        else $error("detect changed before settling");

    // Coded mode passes the filtered detect out
    AST_SD_FOLLOW: assert property (
        cfg.enc_en |=> sig_present_r == $past(sd_r))
        else $error("signal present does not follow detect");

    // Frequency verdict changes only at a window end
    AST_PPM_HOLD: assert property (
        !win_done |=> $stable(ppm_ok_r))
        else $error("frequency verdict changed mid window");

    // No words leave after the first cycle of reference tracking
    AST_NO_WORD_REF: assert property (
        !run_deser |=> !rx_word.valid)
        else $error("word strobed while ignoring data");

    // Short words keep the two top bits clear
    AST_WORD8_PAD: assert property (
        rx_word.valid && !cfg.width10 |-> rx_word.data[9:8] == 2'b00)
        else $error("8-bit word has upper bits set");

    // Manual mode ignores the frequency verdict
    AST_MAN_NO_PPM: assert property (
        !auto_mode && !man.to_ref && man.to_data && !ppm_ok_r
        |=> state_r == cld_pkg::CLD_DATA)
        else $error("manual data tracking held back by ppm");

endmodule
`default_nettype wire

// [cld_tx_model.sv]
/*
 * Far-end transmitter model: serial bit pairs, recovered-clock
 * ticks and the input level seen by the signal comparator.
 * Assumes clk is the local reference clock; drives on falling edges.
 */
`timescale 1ns/1ps
`default_nettype none
module cld_tx_model (
    input  wire logic       clk,      // Reference clock
    input  wire logic [2:0] skip_sh,  // Drop a tick every 2**n, 0 none
    input  wire logic       tick_on,  // Recovered clock present
    input  wire logic       sig_on,   // Line above detect threshold
    output logic            rec_tick, // One tick per recovered cycle
    output logic            level_hi, // Comparator level
    output logic [1:0]      rx_bits   // Two serial bits, bit0 first
);
    int unsigned n = 0;   // Cycle count for tick drops

    // Continuous random stream; ticks thinned to offset frequency
    always @(negedge clk) begin
        n <= n + 1;
        rx_bits  <= 2'($urandom);
        rec_tick <= tick_on && !(skip_sh != 3'h0 &&
                    (n % (1 << skip_sh)) == 0);
        level_hi <= sig_on;
    end
endmodule
`default_nettype wire

// [cld_top_test.sv]
/*
 * Self-checking bench for the lock controller and deserializer,
 * with a queue model of the word stream in manual mode.
 * Assumes cld_top and cld_tx_model are compiled beforehand.
 */
`timescale 1ns/1ps
`default_nettype none
module cld_top_test;
    localparam int W      = 16;        // Shortened frequency window
    localparam int SETTLE = 2 * W + 4; // Worst case lock reaction

    logic                 clk;         // 100 MHz clock
    logic                 rst_n;       // Async reset
    cld_pkg::cld_cfg_t    cfg;         // Static config
    cld_pkg::cld_manual_t man;         // Manual controls
    logic [2:0]           skip_sh;     // Tick thinning
    logic                 tick_on;     // Ticks present
    logic                 sig_on;      // Level above threshold
    logic                 rec_tick;    // From far end
    logic                 level_hi;    // From far end
    logic [1:0]           rx_bits;     // From far end
    logic                 freq_locked; // Lock flag
    logic                 pd_en;       // Phase detector on
    logic                 sig_present; // Filtered detect
    cld_pkg::cld_state_t  state_o;     // Tracking state
    cld_pkg::cld_word_t   rx_word;     // Parallel word
    int                   n_fail = 0;  // Mismatches
    int                   n_checks = 0; // Comparisons
    logic                 mdl_on = 1'b0; // Word model active
    cld_pkg::cld_state_t  exp_st = cld_pkg::CLD_REF; // Model state
    logic [1:0]           pairs[$];    // Pairs of the word in progress
    logic [9:0]           exp_words[$]; // Words still awaited
    logic [9:0]           w_m;         // Word under assembly

    cld_top #(.PPM_WIN(W)) dut (
        .clk(clk), .rst_n(rst_n), .cfg(cfg), .man(man),
        .rec_tick(rec_tick), .level_hi(level_hi), .rx_bits(rx_bits),
        .freq_locked(freq_locked), .pd_en(pd_en),
        .sig_present(sig_present), .state_o(state_o), .rx_word(rx_word)
    );

    cld_tx_model far (
        .clk(clk), .skip_sh(skip_sh), .tick_on(tick_on), .sig_on(sig_on),
        .rec_tick(rec_tick), .level_hi(level_hi), .rx_bits(rx_bits)
    );

    // Clock generator
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // One comparison
    task automatic chk(input string nm, input logic [9:0] e,
                       input logic [9:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    // State, lock flag and detector enable agree with one state
    task automatic chk_st(input cld_pkg::cld_state_t s);
        chk("state_o", 10'(s), 10'(state_o));
        chk("freq_locked", 10'(s == cld_pkg::CLD_DATA), 10'(freq_locked));
        chk("pd_en", 10'(s == cld_pkg::CLD_DATA), 10'(pd_en));
    endtask

    // Verdict and end of run
    task automatic end_sim;
        if (n_fail == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Reset for 6 cycles under a new configuration
    task automatic do_reset(input logic m, input logic p, input logic e,
                            input logic w);
        @(negedge clk);
        rst_n = 1'b0;
        cfg = '{manual_en: m, pipe_mode: p, enc_en: e, width10: w,
                ppm_thresh: 8'h02};
        repeat (6) @(negedge clk);
        chk_st(cld_pkg::CLD_REF);
        rst_n = 1'b1;
    endtask

    // Random manual control sequence with aborted words
    task automatic run_manual(input logic w);
        do_reset(1'b1, 1'b0, 1'b1, w);
        mdl_on = 1'b1;
        repeat (40) begin
            man = ($urandom % 4 == 0) ? 2'($urandom) : 2'b01;
            repeat (1 + $urandom % 12) @(negedge clk);
        end
        man = 2'b00;
        repeat (3) @(negedge clk);
        chk("words_left", 10'h000, 10'(exp_words.size()));
        mdl_on = 1'b0;
    endtask

    // Reference model of state and word assembly
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            exp_st = cld_pkg::CLD_REF;
            pairs.delete();
            exp_words.delete();
        end else if (mdl_on) begin
            if (exp_st == cld_pkg::CLD_DATA) begin
                pairs.push_back(rx_bits);
                if (pairs.size() == (cfg.width10 ? 5 : 4)) begin
                    w_m = 10'h000;
                    foreach (pairs[i]) w_m[2 * i +: 2] = pairs[i];
                    exp_words.push_back(w_m);
                    pairs.delete();
                end
            end else begin
                pairs.delete();
            end
            exp_st = man.to_ref ? cld_pkg::CLD_REF :
                     man.to_data ? cld_pkg::CLD_DATA : cld_pkg::CLD_REF;
        end
    end

    // Compare state and words once outputs have settled
    always @(negedge clk) begin
        if (mdl_on && rst_n) begin
            chk_st(exp_st);
            if (rx_word.valid === 1'b1) begin
                if (exp_words.size() == 0) begin
                    chk("rx_word.valid", 10'h000, 10'h001);
                end else begin
                    chk("rx_word.data", exp_words.pop_front(), rx_word.data);
                end
            end
        end
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_sim();
    end

    // Main sequence
    initial begin
        void'($urandom(68));
        rst_n = 1'b0;
        cfg = '0;
        man = 2'b00;
        skip_sh = 3'h0;
        tick_on = 1'b0;
        sig_on = 1'b0;
        run_manual(1'b0);
        run_manual(1'b1);
        // Automatic mode, manual levels present but ignored
        do_reset(1'b0, 1'b0, 1'b1, 1'b0);
        man = 2'b11;
        tick_on = 1'b1;
        skip_sh = 3'h3;
        repeat (W - 2) @(negedge clk);
        chk_st(cld_pkg::CLD_REF);
        repeat (SETTLE) @(negedge clk);
        chk_st(cld_pkg::CLD_DATA);
        chk("sig_present", 10'h000, 10'(sig_present));
        skip_sh = 3'h2;
        repeat (SETTLE) @(negedge clk);
        chk_st(cld_pkg::CLD_REF);
        skip_sh = 3'h0;
        repeat (SETTLE) @(negedge clk);
        chk_st(cld_pkg::CLD_DATA);
        // PIPE mode gating by signal detect
        do_reset(1'b0, 1'b1, 1'b1, 1'b0);
        repeat (SETTLE) @(negedge clk);
        chk_st(cld_pkg::CLD_REF);
        sig_on = 1'b1;
        repeat (SETTLE) @(negedge clk);
        chk_st(cld_pkg::CLD_DATA);
        chk("sig_present", 10'h001, 10'(sig_present));
        sig_on = 1'b0;
        repeat (10) @(negedge clk);
        chk_st(cld_pkg::CLD_REF);
        chk("sig_present", 10'h000, 10'(sig_present));
        // Detection unsupported without coding
        do_reset(1'b0, 1'b0, 1'b0, 1'b0);
        repeat (2) @(negedge clk);
        chk("sig_present", 10'h001, 10'(sig_present));
        end_sim();
    end
endmodule
`default_nettype wire
